//--- hdl/pos_opt_top.sv
// positioning options, setpoint release, rotary direction, slip and PI readouts
`timescale 1ns/1ns
`include "pos_regs.svh"
module pos_opt_top
  import pos_pkg::*;
#(
  parameter int KP_SHIFT = 2,
  parameter int KI_SHIFT = 8,
  parameter int WIN_W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_od_wr,
  input wire logic i_od_rd,
  input wire logic [15:0] i_od_index,
  input wire logic [31:0] i_od_wdata,
  output logic [31:0] o_od_rdata,
  output logic o_od_ack,
  output logic o_od_err,
  input wire logic i_cw_wr,
  input wire logic [15:0] i_cw_data,
  output logic [15:0] o_ctrl_word,
  output logic o_sw_setpoint_ack,
  output logic o_sw_slip_err,
  input wire logic signed [31:0] i_target_pos,
  input wire logic signed [31:0] i_ramp_pos,
  input wire logic signed [31:0] i_actual_pos,
  input wire logic signed [31:0] i_demand_pos,
  input wire logic signed [31:0] i_range_min,
  input wire logic signed [31:0] i_range_max,
  input wire logic i_target_reached,
  output logic signed [31:0] o_target_pos,
  output logic o_dir_pos,
  output logic o_via_limit,
  output logic o_new_target,
  input wire logic i_pv_mode,
  input wire logic signed [31:0] i_speed_actual,
  input wire logic signed [31:0] i_speed_set,
  input wire logic [WIN_W-1:0] i_slip_window_cyc,
  input wire logic i_slip_react_en,
  output logic o_err_hist_log,
  output logic signed [31:0] o_following_error,
  output logic signed [31:0] o_correction_speed
);
  if (KP_SHIFT < 0 || KP_SHIFT > 31 || KI_SHIFT < 0 || KI_SHIFT > 31) begin : g_chk
    $error("pos_opt_top: gain shifts must be 0..31");
  end

  // ========================================================================
  // object dictionary access
  logic [15:0] opt_q;
  logic [15:0] opt_d;
  logic signed [31:0] slip_q;
  logic signed [31:0] slip_d;
  logic [31:0] rdata_d;
  logic ack_od_d;
  logic err_od_d;

  // one-cycle answer; unknown index or write to a read-only object flags error
  always_comb begin
    opt_d = opt_q;
    slip_d = slip_q;
    rdata_d = o_od_rdata;
    ack_od_d = 1'b0;
    err_od_d = 1'b0;
    if (i_od_wr || i_od_rd) begin
      ack_od_d = 1'b1;
      case (i_od_index)
        `POS_IDX_OPTIONS: begin
          rdata_d = {16'h0000, opt_q};
          if (i_od_wr) begin
            opt_d = i_od_wdata[15:0];
          end
        end
        `POS_IDX_MAXSLIP: begin
          rdata_d = slip_q;
          if (i_od_wr) begin
            slip_d = i_od_wdata;
          end
        end
        `POS_IDX_FERR: begin
          rdata_d = o_following_error;
          err_od_d = i_od_wr;
        end
        `POS_IDX_CORR: begin
          rdata_d = o_correction_speed;
          err_od_d = i_od_wr;
        end
        default: begin
          rdata_d = 32'h00000000;
          err_od_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      opt_q <= `POS_OPT_RESET;
      slip_q <= `POS_MAXSLIP_RESET;
      o_od_rdata <= 32'h00000000;
      o_od_ack <= 1'b0;
      o_od_err <= 1'b0;
    end else begin
      opt_q <= opt_d;
      slip_q <= slip_d;
      o_od_rdata <= rdata_d;
      o_od_ack <= ack_od_d;
      o_od_err <= err_od_d;
    end
  end

  // ========================================================================
  // target computation
  // only these fields are decoded; the rest of the option word is inert
  logic [1:0] rel_sel;
  logic [1:0] rro_sel;
  logic [1:0] rotary_direction_select_sel;
  logic signed [31:0] prev_tgt_q;
  logic signed [31:0] base;
  logic signed [31:0] tgt_abs;
  logic signed [31:0] tgt_w;
  logic signed [31:0] span;
  logic signed [31:0] diff;
  logic signed [31:0] diff_m;
  logic dir_c;
  logic via_c;

  assign rel_sel = opt_q[`POS_REL_LSB +: 2];
  assign rro_sel = opt_q[`POS_RRO_LSB +: 2];
  assign rotary_direction_select_sel = opt_q[`POS_ROTARY_DIRECTION_SELECT_LSB +: 2];

  always_comb begin
    case (rel_sel)
      2'h1: base = i_ramp_pos;
      2'h2: base = i_actual_pos;
      default: base = prev_tgt_q;
    endcase
    tgt_abs = o_ctrl_word[`POS_CW_REL] ? base + i_target_pos : i_target_pos;
    span = i_range_max - i_range_min;
    tgt_w = tgt_abs;
    if (rotary_direction_select_sel == 2'h0 && span > 0) begin
      if (tgt_abs > i_range_max) begin
        tgt_w = i_range_min + (tgt_abs - i_range_max);
      end else if (tgt_abs < i_range_min) begin
        tgt_w = i_range_max - (i_range_min - tgt_abs);
      end
    end
    diff = tgt_w - i_actual_pos;
    diff_m = (diff < 0) ? diff + span : diff;
    case (rotary_direction_select_sel)
      2'h1: begin
        dir_c = 1'b0;
        via_c = tgt_w > i_actual_pos;
      end
      2'h2: begin
        dir_c = 1'b1;
        via_c = tgt_w < i_actual_pos;
      end
      2'h3: begin
        dir_c = diff_m < (span >>> 1);
        via_c = dir_c ? (tgt_w < i_actual_pos) : (tgt_w > i_actual_pos);
      end
      default: begin
        dir_c = diff >= 0;
        via_c = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // new-setpoint handshake
  pos_hs_e hs_q;
  pos_hs_e hs_d;
  logic nsp_prev_q;
  logic [15:0] cw_d;
  logic sack_d;
  logic newt_d;
  logic signed [31:0] tgt_d;
  logic signed [31:0] prev_d;
  logic dir_d;
  logic via_d;
  logic accept;
  logic release_c;

  // master writes to the controlword win over a device release in the same cycle
  always_comb begin
    hs_d = hs_q;
    cw_d = o_ctrl_word;
    sack_d = o_sw_setpoint_ack;
    newt_d = 1'b0;
    tgt_d = o_target_pos;
    prev_d = prev_tgt_q;
    dir_d = o_dir_pos;
    via_d = o_via_limit;
    release_c = 1'b0;
    accept = (hs_q == HS_IDLE) && o_ctrl_word[`POS_CW_NEWSP] && !nsp_prev_q;
    case (hs_q)
      HS_IDLE: begin
        if (accept) begin
          tgt_d = tgt_w;
          prev_d = tgt_w;
          dir_d = dir_c;
          via_d = via_c;
          newt_d = 1'b1;
          sack_d = 1'b1;
          hs_d = HS_WAIT;
        end
      end
      HS_WAIT: begin
        case (rro_sel)
          2'h1: release_c = i_target_reached;
          2'h2: release_c = 1'b1;
          default: begin
            if (!o_ctrl_word[`POS_CW_NEWSP]) begin
              sack_d = 1'b0;
              hs_d = HS_IDLE;
            end
          end
        endcase
      end
      default: hs_d = HS_IDLE;
    endcase
    if (release_c) begin
      cw_d[`POS_CW_NEWSP] = 1'b0;
      sack_d = 1'b0;
      hs_d = HS_IDLE;
    end
    if (i_cw_wr) begin
      cw_d = i_cw_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hs_q <= HS_IDLE;
      nsp_prev_q <= 1'b0;
      o_ctrl_word <= 16'h0000;
      o_sw_setpoint_ack <= 1'b0;
      o_new_target <= 1'b0;
      o_target_pos <= 32'sh00000000;
      prev_tgt_q <= 32'sh00000000;
      o_dir_pos <= 1'b0;
      o_via_limit <= 1'b0;
    end else begin
      hs_q <= hs_d;
      nsp_prev_q <= o_ctrl_word[`POS_CW_NEWSP];
      o_ctrl_word <= cw_d;
      o_sw_setpoint_ack <= sack_d;
      o_new_target <= newt_d;
      o_target_pos <= tgt_d;
      prev_tgt_q <= prev_d;
      o_dir_pos <= dir_d;
      o_via_limit <= via_d;
    end
  end

  // ========================================================================
  // following error and PI correction speed
  // the integral wraps rather than saturates; gains are powers of two
  logic signed [31:0] integ_q;
  logic signed [31:0] integ_d;
  logic signed [31:0] ferr_d;
  logic signed [31:0] corr_d;

  always_comb begin
    ferr_d = i_demand_pos - i_actual_pos;
    integ_d = integ_q + o_following_error;
    corr_d = (o_following_error >>> KP_SHIFT) + (integ_q >>> KI_SHIFT);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      integ_q <= 32'sh00000000;
      o_following_error <= 32'sh00000000;
      o_correction_speed <= 32'sh00000000;
    end else begin
      integ_q <= integ_d;
      o_following_error <= ferr_d;
      o_correction_speed <= corr_d;
    end
  end

  // ========================================================================
  // slip monitor
  // slip status bit
  pos_slip_mon #(
    .CNT_W(WIN_W)
  ) u_slip (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pv_mode(i_pv_mode),
    .i_speed_actual(i_speed_actual),
    .i_speed_set(i_speed_set),
    .i_max_slip(slip_q),
    .i_window_cyc(i_slip_window_cyc),
    .i_react_en(i_slip_react_en),
    .o_slip_err(o_sw_slip_err),
    .o_hist_log(o_err_hist_log)
  );

  // ========================================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_accept;
    accept;
  endsequence
  sequence s_quiet;
    !i_cw_wr;
  endsequence

  a_accept_ack: assert property (s_accept |=> o_sw_setpoint_ack && o_new_target)
    else $error("accepted setpoint not acknowledged");
  a_fast_release: assert property ((s_accept ##1 ((rro_sel == 2'h2) && !i_cw_wr))
    |=> !o_ctrl_word[`POS_CW_NEWSP] && !o_sw_setpoint_ack)
    else $error("immediate release did not happen");
  a_reach_release: assert property ((hs_q == HS_WAIT && rro_sel == 2'h1 && i_target_reached
    && !i_cw_wr) |=> !o_ctrl_word[`POS_CW_NEWSP] && !o_sw_setpoint_ack)
    else $error("release on arrival missed");
  a_hold_ack: assert property ((hs_q == HS_WAIT && rro_sel == 2'h1 && !i_target_reached)
    |=> o_sw_setpoint_ack)
    else $error("acknowledge dropped before arrival");
  a_rel_prev: assert property ((s_accept and (o_ctrl_word[`POS_CW_REL] && rel_sel == 2'h0
    && rotary_direction_select_sel != 2'h0)) |=> o_target_pos == $past(prev_tgt_q) + $past(i_target_pos))
    else $error("relative move not based on previous target");
  a_rel_actual: assert property ((s_accept and (o_ctrl_word[`POS_CW_REL] && rel_sel == 2'h2
    && rotary_direction_select_sel != 2'h0)) |=> o_target_pos == $past(i_actual_pos) + $past(i_target_pos))
    else $error("relative move not based on actual position");
  a_dir_neg: assert property ((s_accept and (rotary_direction_select_sel == 2'h1))
    |=> !o_dir_pos && (o_via_limit == (o_target_pos > $past(i_actual_pos))))
    else $error("negative-only direction violated");
  a_dir_pos: assert property ((s_accept and (rotary_direction_select_sel == 2'h2))
    |=> o_dir_pos && (o_via_limit == (o_target_pos < $past(i_actual_pos))))
    else $error("positive-only direction violated");
endmodule : pos_opt_top

//--- hdl/pos_regs.svh
// object indices, field positions and reset values of the positioning option block
// ==========================================================================
// Functional notes
// - only the documented option fields act; other option bits are inert
// - option bits 1..0 pick relative base when controlword bit 6 is set
// - base 00 adds to the previous absolute target, zero if none yet
// - release 00: master clears new-setpoint bit 4; code 11 reserved
// - release 01: device clears new-setpoint once the movement reached target
// - release 10: device clears new-setpoint at the earliest possible moment
// - device clearing new-setpoint also clears statusword acknowledge bit 12
// - direction 00: linear axis, setpoint wraps to the opposite range limit
// - direction 01: negative only, passing the minimum limit if needed
// - direction 10: positive only, passing the maximum limit if needed
// - direction 11: shortest path, positive when under half a turn
// - following error reads as signed 32-bit value, read only
// - velocity mode: statusword bit 13 set when speed slip exceeds maximum
// - slip flagged only after lasting longer than the slip time window
// - maximum slip of the largest positive value disables slip monitoring
// - with a slip reaction configured, log an error history entry
// - PI correction speed from position error, fed on and readable
`ifndef POS_REGS_SVH
`define POS_REGS_SVH

// ==========================================================================
// object indices
`define POS_IDX_OPTIONS 16'h60F2
`define POS_IDX_FERR 16'h60F4
`define POS_IDX_MAXSLIP 16'h60F8
`define POS_IDX_CORR 16'h60FA

// ==========================================================================
// reset values
`define POS_OPT_RESET 16'h0001
`define POS_MAXSLIP_RESET 32'h00000190
`define POS_SLIP_OFF 32'h7FFFFFFF

// ==========================================================================
// field positions
`define POS_REL_LSB 0
`define POS_RRO_LSB 4
`define POS_ROTARY_DIRECTION_SELECT_LSB 6
`define POS_CW_NEWSP 4
`define POS_CW_REL 6

`endif

//--- hdl/pos_pkg.sv
// types shared by the positioning option block
package pos_pkg;
  // handshake states of the new-setpoint exchange
  typedef enum logic {HS_IDLE, HS_WAIT} pos_hs_e;
  typedef logic signed [31:0] pos_word_t;
endpackage : pos_pkg

//--- hdl/pos_slip_mon.sv
// speed slippage monitor with persistence window
`timescale 1ns/1ns
`include "pos_regs.svh"
module pos_slip_mon
  import pos_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_pv_mode,
  input wire logic signed [31:0] i_speed_actual,
  input wire logic signed [31:0] i_speed_set,
  input wire logic signed [31:0] i_max_slip,
  input wire logic [CNT_W-1:0] i_window_cyc,
  input wire logic i_react_en,
  output logic o_slip_err,
  output logic o_hist_log
);
  if (CNT_W < 8 || CNT_W > 32) begin : g_chk
    $error("pos_slip_mon: CNT_W must be 8..32");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic err_d;
  logic hist_d;
  logic signed [32:0] diff;
  logic [32:0] mag;
  logic [32:0] lim;
  logic over;

  // ========================================================================
  // deviation detection
  // 33-bit difference so opposite-sign extremes cannot overflow
  always_comb begin
    diff = 33'(i_speed_actual) - 33'(i_speed_set);
    mag = diff[32] ? 33'(-diff) : 33'(diff);
    lim = i_max_slip[31] ? 33'(-33'(i_max_slip)) : 33'(i_max_slip);
    over = i_pv_mode && (i_max_slip != `POS_SLIP_OFF) && (mag > lim);
  end

  // persistence counter and flag
  always_comb begin
    cnt_d = '0;
    if (over && cnt_q != '1) begin
      cnt_d = cnt_q + 1'b1;
    end else if (over) begin
      cnt_d = cnt_q;
    end
    err_d = over && (cnt_q >= i_window_cyc);
    hist_d = err_d && !o_slip_err && i_react_en;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      o_slip_err <= 1'b0;
      o_hist_log <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_slip_err <= err_d;
      o_hist_log <= hist_d;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_slip_persist: assert property ($rose(o_slip_err) |-> $past(cnt_q) >= $past(i_window_cyc))
    else $error("slip flag rose before the window elapsed");
  a_slip_off: assert property ((i_max_slip == `POS_SLIP_OFF) |=> !o_slip_err)
    else $error("slip flagged while monitoring is off");
  a_hist_entry: assert property (o_hist_log |-> $rose(o_slip_err) && $past(i_react_en))
    else $error("history entry without a fresh slip error");
endmodule : pos_slip_mon

//--- dv/pos_master_model.sv
// model of the fieldbus master that writes objects and the controlword
`timescale 1ns/1ns
module pos_master_model (
  input wire logic i_sys_clk,
  input wire logic [31:0] i_od_rdata,
  input wire logic i_od_ack,
  input wire logic i_od_err,
  output logic o_od_wr,
  output logic o_od_rd,
  output logic [15:0] o_od_index,
  output logic [31:0] o_od_wdata,
  output logic o_cw_wr,
  output logic [15:0] o_cw_data
);
  // idle bus at time zero
  initial begin
    o_od_wr = 1'b0;
    o_od_rd = 1'b0;
    o_od_index = 16'h0000;
    o_od_wdata = 32'h0;
    o_cw_wr = 1'b0;
    o_cw_data = 16'h0000;
  end

  // one object access; released words are inverted so stale values never help the design
  task automatic od(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                    output logic [31:0] rd, output logic er);
    rd = 'x;
    er = 1'bx;
    @(posedge i_sys_clk);
    #1;
    o_od_wr = wr;
    o_od_rd = !wr;
    o_od_index = idx;
    o_od_wdata = wd;
    @(posedge i_sys_clk);
    #1;
    o_od_wr = 1'b0;
    o_od_rd = 1'b0;
    o_od_index = ~idx;
    o_od_wdata = ~wd;
    for (int i = 0; i < 4; i++) begin
      if (i_od_ack === 1'b1) begin
        rd = i_od_rdata;
        er = i_od_err;
        break;
      end
      @(posedge i_sys_clk);
      #1;
    end
  endtask : od

  // controlword write strobe, one cycle
  task automatic cw_write(input logic [15:0] data);
    @(posedge i_sys_clk);
    #1;
    o_cw_wr = 1'b1;
    o_cw_data = data;
    @(posedge i_sys_clk);
    #1;
    o_cw_wr = 1'b0;
    o_cw_data = ~data;
  endtask : cw_write
endmodule : pos_master_model

//--- dv/test_positioning_option_slip_monitor.sv
// self-checking bench for the positioning option block
`timescale 1ns/1ns
`include "pos_regs.svh"
module test_positioning_option_slip_monitor;
  import pos_pkg::*;
  typedef struct {
    logic [15:0] opt, cw;
    logic signed [31:0] tgt, exp_tgt;
    logic dir, via;
    logic [1:0] chk;
  } pos_row_s;
  logic sys_clk = 1'b0, rst = 1'b1, od_wr, od_rd, od_ack, od_err, cw_wr, sw_ack, sw_slip;
  logic tgt_reached = 1'b0, dir_pos, via_limit, new_tgt, pv_mode = 1'b0, react_en = 1'b0;
  logic hist_log, er, saw_log;
  logic [15:0] od_index, cw_data, ctrl_word;
  logic [31:0] od_wdata, od_rdata, slip_win = 32'h4, rd;
  logic signed [31:0] target_pos = 32'sh0, actual_pos = 32'sd500, o_tgt, ferr, corr;
  logic signed [31:0] spd_act = 32'sd1000;
  logic signed [31:0] ramp_pos = 32'sd1000, demand_pos = 32'sd560, spd_set = 32'sd1000;
  int n_errors = 0, comparisons = 0;
  // object rows: write, index, data, expected read data, expected error
  logic [15:0] oi[11] = '{16'h60F2, 16'h60F8, 16'h60F4, 16'h60F4, 16'h60FA, 16'h1234,
                          16'h60F8, 16'h60F8, 16'h60F2, 16'h60F2, 16'h60F4};
  logic ow[11] = '{0, 0, 0, 1, 1, 0, 1, 0, 1, 0, 0};
  logic [31:0] od_d[11] = '{0, 0, 0, 5, 5, 0, 100, 0, 32'hFFFF, 0, 0};
  logic [31:0] oe[11] = '{32'h1, 32'h190, 32'd60, 0, 0, 0, 0, 32'd100, 0, 32'hFFFF, 32'd60};
  logic oerr[11] = '{0, 0, 0, 1, 1, 1, 0, 0, 0, 0, 0};
  // move rows, release mode 10 throughout; chk bit0 checks direction, bit1 the limit flag
  pos_row_s mv[11] = '{
    '{16'h0020, 16'h0050, 10, 10, 0, 0, 0}, '{16'h00E0, 16'h0050, 10, 20, 0, 0, 0},
    '{16'h0021, 16'h0050, 10, 1010, 0, 0, 0}, '{16'h00E2, 16'h0050, 10, 510, 0, 0, 0},
    '{16'h0023, 16'h0050, 10, 520, 0, 0, 0}, '{16'h0060, 16'h0010, 700, 700, 0, 1, 3},
    '{16'h00A0, 16'h0010, 300, 300, 1, 1, 3}, '{16'h00E0, 16'h0010, 900, 900, 1, 0, 1},
    '{16'h00E0, 16'h0010, 3000, 3000, 0, 0, 1}, '{16'h0020, 16'h0010, 3700, 100, 0, 0, 0},
    '{16'hFF2C, 16'h0050, 5, 105, 0, 0, 0}};

  pos_master_model i_pos_master_model (.i_sys_clk(sys_clk), .i_od_rdata(od_rdata),
    .i_od_ack(od_ack), .i_od_err(od_err), .o_od_wr(od_wr), .o_od_rd(od_rd),
    .o_od_index(od_index), .o_od_wdata(od_wdata), .o_cw_wr(cw_wr), .o_cw_data(cw_data));

  pos_opt_top i_pos_opt_top (.i_sys_clk(sys_clk), .i_rst(rst), .i_od_wr(od_wr),
    .i_od_rd(od_rd), .i_od_index(od_index), .i_od_wdata(od_wdata), .o_od_rdata(od_rdata),
    .o_od_ack(od_ack), .o_od_err(od_err), .i_cw_wr(cw_wr), .i_cw_data(cw_data),
    .o_ctrl_word(ctrl_word), .o_sw_setpoint_ack(sw_ack), .o_sw_slip_err(sw_slip),
    .i_target_pos(target_pos), .i_ramp_pos(ramp_pos), .i_actual_pos(actual_pos),
    .i_demand_pos(demand_pos), .i_range_min(32'sd0), .i_range_max(32'sd3600),
    .i_target_reached(tgt_reached), .o_target_pos(o_tgt), .o_dir_pos(dir_pos),
    .o_via_limit(via_limit), .o_new_target(new_tgt), .i_pv_mode(pv_mode),
    .i_speed_actual(spd_act), .i_speed_set(spd_set), .i_slip_window_cyc(slip_win),
    .i_slip_react_en(react_en), .o_err_hist_log(hist_log), .o_following_error(ferr),
    .o_correction_speed(corr));

  // ==========================================================================
  // helpers
  always #25 sys_clk = ~sys_clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // bounded wait for the acceptance pulse of a new setpoint
  task automatic wait_new();
    for (int i = 0; i < 8; i++) begin
      tick(1);
      if (new_tgt === 1'b1) return;
    end
    check("new target pulse", new_tgt, 1'b1);
  endtask : wait_new

  task automatic opt_wr(input logic [15:0] v);
    i_pos_master_model.od(1'b1, `POS_IDX_OPTIONS, {16'h0, v}, rd, er);
  endtask : opt_wr

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // a hang counts as a mismatch and ends the run the normal way
  initial begin
    #(50 * 6000);
    n_errors++;
    wrap_up();
  end

  // ==========================================================================
  // main sequence
  initial begin
    tick(16);
    rst = 1'b0;
    // third edge after reset: error 60, integral 60, effort 60/4 + 60/256
    tick(3);
    check("following error", ferr, 32'd60);
    check("correction speed", corr, 32'd15);
    for (int k = 0; k < 11; k++) begin
      i_pos_master_model.od(ow[k], oi[k], od_d[k], rd, er);
      check("object error", er, oerr[k]);
      if (!ow[k]) check("object data", rd, oe[k]);
    end
    for (int k = 0; k < 11; k++) begin
      opt_wr(mv[k].opt);
      target_pos = mv[k].tgt;
      i_pos_master_model.cw_write(mv[k].cw);
      wait_new();
      check("target", o_tgt, mv[k].exp_tgt);
      check("acknowledge set", sw_ack, 1'b1);
      if (mv[k].chk[0]) check("direction", dir_pos, mv[k].dir);
      if (mv[k].chk[1]) check("via limit", via_limit, mv[k].via);
      tick(1);
      check("release bit", ctrl_word[`POS_CW_NEWSP], 1'b0);
      check("acknowledge clear", sw_ack, 1'b0);
    end
    // release 00: handshake stays until the master lowers the bit
    opt_wr(16'h0000);
    actual_pos = 32'sd600;
    i_pos_master_model.cw_write(16'h0010);
    wait_new();
    tick(4);
    check("held acknowledge", sw_ack, 1'b1);
    i_pos_master_model.cw_write(16'h0000);
    tick(2);
    check("acknowledge after clear", sw_ack, 1'b0);
    // release 01: only a reached target lets go
    opt_wr(16'h0010);
    i_pos_master_model.cw_write(16'h0010);
    wait_new();
    tick(4);
    check("waiting bit", ctrl_word[`POS_CW_NEWSP], 1'b1);
    tgt_reached = 1'b1;
    tick(2);
    check("reached bit", ctrl_word[`POS_CW_NEWSP], 1'b0);
    check("reached acknowledge", sw_ack, 1'b0);
    tgt_reached = 1'b0;
    // slip monitor: window of four cycles, then a flag and a history entry
    pv_mode = 1'b1;
    react_en = 1'b1;
    saw_log = 1'b0;
    spd_act = 32'sd1200;
    tick(4);
    check("early slip", sw_slip, 1'b0);
    for (int i = 0; i < 6 && sw_slip !== 1'b1; i++) begin
      tick(1);
      saw_log |= hist_log;
    end
    check("slip flag", sw_slip, 1'b1);
    check("history entry", saw_log, 1'b1);
    spd_act = 32'sd1000;
    tick(2);
    check("slip gone", sw_slip, 1'b0);
    i_pos_master_model.od(1'b1, `POS_IDX_MAXSLIP, `POS_SLIP_OFF, rd, er);
    spd_act = 32'sd1200;
    tick(12);
    check("slip disabled", sw_slip, 1'b0);
    wrap_up();
  end
endmodule : test_positioning_option_slip_monitor
